// *** rdsp_pkg.sv ***
// Shared constants and types of the reference level serial programming port
package rdsp_pkg;

   // ------------------------------------------------------------
   // Serial word layout
   // ------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int TEST_BIT = 15;
   localparam int OSC_SOURCE_BIT = 14;
   localparam int ADDR_MSB = 13;
   localparam int ADDR_LSB = 10;
   localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
   localparam int LEVEL_MSB = 9;
   localparam int LEVEL_LSB = 0;
   localparam int LEVEL_W = LEVEL_MSB - LEVEL_LSB + 1;

   // ------------------------------------------------------------
   // Channel count and bit counter
   // ------------------------------------------------------------
   localparam int CHANNELS = 12;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_FULL = 5'h10;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_FIRST = 5'h01;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h000;
   localparam logic OSC_EXT_RESET = 1'b0;

   // ------------------------------------------------------------
   // Timing: system clock and internal refresh oscillator
   // ------------------------------------------------------------
   localparam int SYS_CLK_HZ = 25_000_000;
   localparam int OSC_FREQ_HZ = 21_000;
   // Half period no longer than the exact value, so rounded down
   localparam int OSC_HALF_CYCLES = SYS_CLK_HZ / (2 * OSC_FREQ_HZ);
   localparam int OSC_CNT_W = 10;

   // ------------------------------------------------------------
   // Update sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_CAPTURE = 3'h2,
      ST_COMMIT = 3'h4
   } rdsp_state_t;

endpackage : rdsp_pkg

// *** rdsp_link_if.sv ***
// Carrier between the serial-clock shifter and the system-clock core
`timescale 1ns/1ps
interface rdsp_link_if;
   logic [rdsp_pkg::WORD_BITS-1:0] word;
   logic word_full;
   logic serial_out;

   modport shifter (output word, output word_full, output serial_out);
   modport core (input word, input word_full, input serial_out);
endinterface : rdsp_link_if

// *** rdsp_shifter.sv ***
// Serial-clock domain shift register, bit counter and chain output
`timescale 1ns/1ps
module rdsp_shifter (
   input wire logic sclk_in,
   input wire logic chip_select_n_in,
   input wire logic serial_in_pin_in,
   rdsp_link_if.shifter link
);

   logic [rdsp_pkg::WORD_BITS-1:0] shift_r;
   logic [rdsp_pkg::WORD_BITS-1:0] shift_nxt;
   logic [rdsp_pkg::BIT_CNT_W-1:0] count_r;
   logic [rdsp_pkg::BIT_CNT_W-1:0] count_nxt;
   logic fresh_r;
   logic sdo_r;
   logic count_sat;

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   // Oldest bit leaves at the top, so the first bit sent ends as bit 15
   assign shift_nxt =
      {shift_r[rdsp_pkg::WORD_BITS-2:0], serial_in_pin_in};
   assign count_sat = (count_r == rdsp_pkg::BIT_CNT_FULL);
   // Saturates: extra bits keep only the latest sixteen in the word
   assign count_nxt = fresh_r ? rdsp_pkg::BIT_CNT_FIRST :
      (count_sat ? count_r : count_r + 5'h01);

   // Frame start marker, preset while select is high between frames
   always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
      if (chip_select_n_in) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // Shift on rising edges only while selected; edges outside are ignored
   always_ff @(posedge sclk_in) begin
      if (!chip_select_n_in) begin
         shift_r <= shift_nxt;
         count_r <= count_nxt;
      end
   end

   // Chain output on falling edge: bit seen at 16th falling edge
   always_ff @(negedge sclk_in) begin
      if (!chip_select_n_in) begin
         sdo_r <= shift_r[rdsp_pkg::TEST_BIT];
      end
   end

   // ------------------------------------------------------------
   // Towards the core; stable while select is high
   // ------------------------------------------------------------
   assign link.word = shift_r;
   assign link.word_full = count_sat;
   assign link.serial_out = sdo_r;

endmodule : rdsp_shifter

// *** rdsp_top.sv ***
// Serial programming port of a twelve channel reference level generator
//
// Operation
// - While selected, rising clock shifts input into 16-bit shifter.
// - Words travel most significant bit first, bit 0 last.
// - Select rising after a full word updates the addressed channel.
// - Serial clock edges are ignored while select is high.
// - Chain output copies shifter; bit leaves at 16th falling edge.
// - Chained devices all update together when shared select rises.
// - Bit 14 picks refresh source: zero internal, one external.
// - Bits 13 to 10 hold binary channel address, A is zero.
// - Bits 9 to 0 hold the unsigned level code latched.
// - Floating shutdown input enables, high shutdown input disables.
// - Refresh pin is input when external, oscillator output once programmed internal.
// - Power-up in internal mode; refresh pin released until programmed.
// - Internal refresh oscillator near 21 kHz, may drive the pin.
`timescale 1ns/1ps
module rdsp_top #(
   parameter int NUM_CHANNELS = rdsp_pkg::CHANNELS
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic sclk_in,
   input wire logic chip_select_n_in,
   input wire logic serial_in_pin_in,
   output logic serial_out_pin_out,
   input wire logic shutdown_in,
   input wire logic refresh_clock_pin_in,
   output logic refresh_clock_pin_out,
   output logic refresh_clock_pin_oe_n_out,
   output logic device_enabled_out,
   output logic osc_external_out,
   output logic refresh_clk_out,
   output logic [NUM_CHANNELS-1:0][rdsp_pkg::LEVEL_W-1:0] level_code_out,
   output logic update_pulse_out,
   output logic [rdsp_pkg::ADDR_W-1:0] update_channel_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // The four-bit address field reaches sixteen channels at most
   generate
      if (NUM_CHANNELS < 1 ||
          NUM_CHANNELS > (1 << rdsp_pkg::ADDR_W)) begin : g_bad
         $error("NUM_CHANNELS must lie between 1 and 16");
      end
   endgenerate

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam logic [rdsp_pkg::OSC_CNT_W-1:0] OSC_LAST =
      rdsp_pkg::OSC_CNT_W'(rdsp_pkg::OSC_HALF_CYCLES - 1);
   localparam logic [rdsp_pkg::ADDR_W:0] CHAN_LIMIT =
      (rdsp_pkg::ADDR_W + 1)'(NUM_CHANNELS);

   rdsp_link_if link ();

   rdsp_pkg::rdsp_state_t state_r;
   rdsp_pkg::rdsp_state_t state_nxt;

   logic cs_meta_r;
   logic cs_sync_r;
   logic cs_prev_r;
   logic cs_rise;

   logic [rdsp_pkg::WORD_BITS-1:0] word_r;
   logic full_r;
   logic word_osc;
   logic [rdsp_pkg::ADDR_W-1:0] word_addr;
   logic [rdsp_pkg::LEVEL_W-1:0] word_level;
   logic addr_ok;
   logic commit_any;
   logic commit_chan;

   logic [NUM_CHANNELS-1:0][rdsp_pkg::LEVEL_W-1:0] level_r;
   logic update_pulse_r;
   logic [rdsp_pkg::ADDR_W-1:0] update_chan_r;

   logic osc_ext_r;
   logic programmed_r;
   logic [rdsp_pkg::OSC_CNT_W-1:0] osc_cnt_r;
   logic [rdsp_pkg::OSC_CNT_W-1:0] osc_cnt_nxt;
   logic osc_wrap;
   logic osc_int_r;
   logic ext_meta_r;
   logic ext_sync_r;
   logic refresh_clk_r;
   logic pin_out_r;
   logic pin_oe_n_r;
   logic pin_drive;

   logic shutdown_in_meta_r;
   logic shutdown_in_sync_r;
   logic enabled_r;

   // ------------------------------------------------------------
   // Serial-clock domain
   // ------------------------------------------------------------
   // Shifter runs on the host clock; sampling there is exact to the edge
   rdsp_shifter u_shifter (
      .sclk_in(sclk_in),
      .chip_select_n_in(chip_select_n_in),
      .serial_in_pin_in(serial_in_pin_in),
      .link(link.shifter)
   );

   // Chain output straight from the shifter's falling-edge flop
   assign serial_out_pin_out = link.serial_out;

   // ------------------------------------------------------------
   // Select crossing and frame end detection
   // ------------------------------------------------------------
   // Two flops before use; idle level is high so reset shows no edge
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cs_meta_r <= 1'b1;
         cs_sync_r <= 1'b1;
         cs_prev_r <= 1'b1;
      end else begin
         cs_meta_r <= chip_select_n_in;
         cs_sync_r <= cs_meta_r;
         cs_prev_r <= cs_sync_r;
      end
   end

   // Frame end; the shifter is frozen now since its clock is ignored
   assign cs_rise = cs_sync_r & ~cs_prev_r;

   // ------------------------------------------------------------
   // Update sequencer
   // ------------------------------------------------------------
   // Word is quasi-static after select rises, so it crosses as a bus
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rdsp_pkg::ST_IDLE: begin
            if (cs_rise) begin
               state_nxt = rdsp_pkg::ST_CAPTURE;
            end
         end
         rdsp_pkg::ST_CAPTURE: begin
            state_nxt = rdsp_pkg::ST_COMMIT;
         end
         rdsp_pkg::ST_COMMIT: begin
            state_nxt = rdsp_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = rdsp_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         state_r <= rdsp_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Capture of the frozen word and its completeness flag
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         word_r <= '0;
         full_r <= 1'b0;
      end else if (state_r == rdsp_pkg::ST_CAPTURE) begin
         word_r <= link.word;
         full_r <= link.word_full;
      end
   end

   // ------------------------------------------------------------
   // Word decode
   // ------------------------------------------------------------
   // Test bit is not looked at; the host keeps it zero
   assign word_osc = word_r[rdsp_pkg::OSC_SOURCE_BIT];
   assign word_addr = word_r[rdsp_pkg::ADDR_MSB:rdsp_pkg::ADDR_LSB];
   assign word_level =
      word_r[rdsp_pkg::LEVEL_MSB:rdsp_pkg::LEVEL_LSB];
   assign addr_ok = ({1'b0, word_addr} < CHAN_LIMIT);
   // Short frames are dropped whole
   assign commit_any = (state_r == rdsp_pkg::ST_COMMIT) & full_r;
   assign commit_chan = commit_any & addr_ok;

   // ------------------------------------------------------------
   // Channel level registers
   // ------------------------------------------------------------
   // One latch per channel; a chain updates together on shared select
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
         always_ff @(posedge clk_sys_in) begin
            if (srst_in) begin
               level_r[gi] <= rdsp_pkg::LEVEL_RESET;
            end else if (commit_chan &&
                         word_addr == rdsp_pkg::ADDR_W'(gi)) begin
               level_r[gi] <= word_level;
            end
         end
      end
   endgenerate

   // Update report, one cycle wide, only for a channel really written
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         update_pulse_r <= 1'b0;
         update_chan_r <= '0;
      end else begin
         update_pulse_r <= commit_chan;
         if (commit_chan) begin
            update_chan_r <= word_addr;
         end
      end
   end

   // ------------------------------------------------------------
   // Refresh clock source
   // ------------------------------------------------------------
   // Every complete word carries the source bit, even to a bad address
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         osc_ext_r <= rdsp_pkg::OSC_EXT_RESET;
         programmed_r <= 1'b0;
      end else if (commit_any) begin
         osc_ext_r <= word_osc;
         programmed_r <= 1'b1;
      end
   end

   // Internal oscillator divider, half period rounded down
   assign osc_wrap = (osc_cnt_r == OSC_LAST);
   assign osc_cnt_nxt = osc_wrap ? '0 : osc_cnt_r + 10'h001;

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         osc_cnt_r <= '0;
         osc_int_r <= 1'b0;
      end else begin
         osc_cnt_r <= osc_cnt_nxt;
         if (osc_wrap) begin
            osc_int_r <= ~osc_int_r;
         end
      end
   end

   // External refresh clock is a pin, so two flops first
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end else begin
         ext_meta_r <= refresh_clock_pin_in;
         ext_sync_r <= ext_meta_r;
      end
   end

   // Pin drives only once programmed to internal mode, so no contention
   assign pin_drive = programmed_r & ~osc_ext_r;

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         refresh_clk_r <= 1'b0;
         pin_out_r <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end else begin
         refresh_clk_r <= osc_ext_r ? ext_sync_r : osc_int_r;
         pin_out_r <= osc_int_r;
         pin_oe_n_r <= ~pin_drive;
      end
   end

   // ------------------------------------------------------------
   // Shutdown
   // ------------------------------------------------------------
   // A floating pin is seen low by the pad pull-down; high disables
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         shutdown_in_meta_r <= 1'b1; // Reset as disabled: no false wake
         shutdown_in_sync_r <= 1'b1;
         enabled_r <= 1'b0;
      end else begin
         shutdown_in_meta_r <= shutdown_in;
         shutdown_in_sync_r <= shutdown_in_meta_r;
         enabled_r <= ~shutdown_in_sync_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flops
   // ------------------------------------------------------------
   assign level_code_out = level_r;
   assign update_pulse_out = update_pulse_r;
   assign update_channel_out = update_chan_r;
   assign osc_external_out = osc_ext_r;
   assign refresh_clk_out = refresh_clk_r;
   assign refresh_clock_pin_out = pin_out_r;
   assign refresh_clock_pin_oe_n_out = pin_oe_n_r;
   assign device_enabled_out = enabled_r;

endmodule : rdsp_top

// *** rdsp_monitor.sv ***
// Concurrent checks on the serial programming port top
`timescale 1ns/1ps
module rdsp_monitor #(
   parameter int NUM_CHANNELS = 12
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic chip_select_n_in,
   input wire logic shutdown_in,
   input wire logic refresh_clock_pin_in,
   input wire logic refresh_clock_pin_out,
   input wire logic refresh_clock_pin_oe_n_out,
   input wire logic device_enabled_out,
   input wire logic osc_external_out,
   input wire logic refresh_clk_out,
   input wire logic [NUM_CHANNELS-1:0][rdsp_pkg::LEVEL_W-1:0] level_code_out,
   input wire logic update_pulse_out,
   input wire logic [rdsp_pkg::ADDR_W-1:0] update_channel_out
);
   // Half period plus slack over the divider count, which is rounded down
   localparam int OSC_LIMIT = 600;
   logic pin_q_r;
   int run_cnt_r;
   wire run_clear = srst_in || refresh_clock_pin_oe_n_out ||
                    (pin_q_r != refresh_clock_pin_out);

   // Cycles since the driven refresh pin last changed
   always_ff @(posedge clk_sys_in) begin
      pin_q_r <= refresh_clock_pin_out;
      run_cnt_r <= run_clear ? 0 : run_cnt_r + 1;
   end

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);

   pulse_single_a: assert property (update_pulse_out |=>
      !update_pulse_out)
      else $error("update pulse longer than one cycle");
   pulse_after_select_a: assert property (update_pulse_out |->
      chip_select_n_in && $past(chip_select_n_in, 3))
      else $error("update without a closed frame");
   level_hold_a: assert property (!update_pulse_out |->
      $stable(level_code_out))
      else $error("level changed without update");
   channel_hold_a: assert property (!update_pulse_out |->
      $stable(update_channel_out))
      else $error("channel changed without update");
   channel_range_a: assert property (update_pulse_out |->
      update_channel_out < NUM_CHANNELS)
      else $error("update of a missing channel");
   pin_drive_a: assert property (!refresh_clock_pin_oe_n_out |->
      !$past(osc_external_out))
      else $error("pin driven in external mode");
   ext_follow_a: assert property (osc_external_out &&
      $past(osc_external_out, 4) |->
      refresh_clk_out == $past(refresh_clock_pin_in, 3))
      else $error("refresh clock not following pin");
   osc_period_a: assert property (!refresh_clock_pin_oe_n_out |->
      run_cnt_r <= OSC_LIMIT)
      else $error("internal oscillator stuck");
   enable_follow_a: assert property (!$past(srst_in) &&
      !$past(srst_in, 2) && !$past(srst_in, 3) |->
      device_enabled_out == !$past(shutdown_in, 3))
      else $error("enable not following shutdown");
endmodule : rdsp_monitor

bind rdsp_top rdsp_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) u_monitor (
   .clk_sys_in(clk_sys_in), .srst_in(srst_in),
   .chip_select_n_in(chip_select_n_in), .shutdown_in(shutdown_in),
   .refresh_clock_pin_in(refresh_clock_pin_in),
   .refresh_clock_pin_out(refresh_clock_pin_out),
   .refresh_clock_pin_oe_n_out(refresh_clock_pin_oe_n_out),
   .device_enabled_out(device_enabled_out),
   .osc_external_out(osc_external_out), .refresh_clk_out(refresh_clk_out),
   .level_code_out(level_code_out), .update_pulse_out(update_pulse_out),
   .update_channel_out(update_channel_out));

// *** rdsp_host_model.sv ***
// Host controller model driving the three-wire serial port
`timescale 1ns/1ps
module rdsp_host_model (
   output logic sclk_out,
   output logic chip_select_n_out,
   output logic serial_in_pin_out,
   input wire logic serial_out_pin_in
);
   // Half of the 15 ns link period; clock stands low outside frames apart from noise clocks
   // Faster than a real host may run; only stresses the select crossing
   localparam realtime HALF = 7.5;
   logic [31:0] seen_r;

   initial begin
      sclk_out = 1'b0;
      chip_select_n_out = 1'b1;
      serial_in_pin_out = 1'b0;
      seen_r = '0;
   end

   // Sends bits n-1 down to 0 of w; noise clocks while deselected
   task automatic send(input logic [31:0] w, input int n, input bit noise);
      int i;
      if (noise) repeat (3) begin
         #HALF sclk_out = 1'b1;
         serial_in_pin_out = ~serial_in_pin_out;
         #HALF sclk_out = 1'b0;
      end
      #HALF chip_select_n_out = 1'b0;
      for (i = n - 1; i >= 0; i--) begin
         serial_in_pin_out = w[i];
         #HALF sclk_out = 1'b1;
         #HALF sclk_out = 1'b0;
         #2 seen_r = {seen_r[30:0], serial_out_pin_in};
      end
      #HALF chip_select_n_out = 1'b1;
      // Released line must not look like the last bit
      serial_in_pin_out = ~serial_in_pin_out;
   endtask : send
endmodule : rdsp_host_model

// *** rdsp_tb_top.sv ***
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module rdsp_tb_top;
   localparam int NCH = 12;
   typedef struct packed {
      logic [3:0] ch;
      logic [9:0] lvl;
   } rdsp_note_t;
   logic clk_sys_in, srst_in, shutdown_in, refresh_clock_pin_in;
   logic sclk, csn, serial_in_pin, serial_out_pin, pin_out, pin_oe_n, dev_en, osc_ext, rclk, upd;
   logic [3:0] upd_ch;
   logic [15:0] w1, w2;
   logic [NCH-1:0][9:0] lvl_out, lvl_exp;
   rdsp_note_t notes[$];
   int n_fail, num_checks, seed, cnt, i;

   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   rdsp_host_model host (.sclk_out(sclk), .chip_select_n_out(csn),
      .serial_in_pin_out(serial_in_pin), .serial_out_pin_in(serial_out_pin));
   rdsp_top #(.NUM_CHANNELS(NCH)) dut (.clk_sys_in(clk_sys_in),
      .srst_in(srst_in), .sclk_in(sclk), .chip_select_n_in(csn),
      .serial_in_pin_in(serial_in_pin), .serial_out_pin_out(serial_out_pin),
      .shutdown_in(shutdown_in), .refresh_clock_pin_in(refresh_clock_pin_in),
      .refresh_clock_pin_out(pin_out), .refresh_clock_pin_oe_n_out(pin_oe_n),
      .device_enabled_out(dev_en), .osc_external_out(osc_ext),
      .refresh_clk_out(rclk), .level_code_out(lvl_out),
      .update_pulse_out(upd), .update_channel_out(upd_ch));

   task automatic chk_val(input logic [127:0] got, input logic [127:0] exp,
                          input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk_val

   task automatic chk_note(input rdsp_note_t nt);
      chk_val(upd_ch, nt.ch, "update channel");
      chk_val(lvl_out[nt.ch], nt.lvl, "written level");
   endtask : chk_note

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results

   function automatic logic [15:0] mk(input logic osc, input logic [3:0] ad,
                                      input logic [9:0] lv);
      return {1'b0, osc, ad, lv};
   endfunction : mk

   // Notes the expected update, sends, then keeps select idle
   task automatic frame(input logic [31:0] w, input int n, input bit noise,
                        input bit upd_exp);
      rdsp_note_t nt;
      nt = '{ch: w[13:10], lvl: w[9:0]};
      if (upd_exp) begin
         notes.push_back(nt);
         lvl_exp[nt.ch] = nt.lvl;
      end
      host.send(w, n, noise);
      repeat (10) @(negedge clk_sys_in);
   endtask : frame

   task automatic settle(input string name);
      chk_val(notes.size(), 0, "missing update");
      chk_val(lvl_out, lvl_exp, "level image");
      $display("test %s done", name);
   endtask : settle

   // Negedges until the driven refresh pin changes, bounded
   task automatic edge_wait(output int c);
      logic x;
      x = pin_out;
      c = 0;
      while (pin_out === x && c < 700) begin
         @(negedge clk_sys_in);
         c++;
      end
   endtask : edge_wait

   // Scoreboard: oldest note against each update pulse
   always @(negedge clk_sys_in) begin
      if (upd === 1'b1) begin
         if (notes.size() == 0) begin
            chk_val(1'b1, 1'b0, "unexpected update");
         end else begin
            chk_note(notes.pop_front());
         end
      end
   end

   initial begin
      srst_in = 1'b1;
      shutdown_in = 1'b0;
      refresh_clock_pin_in = 1'b0;
      lvl_exp = '0;
      n_fail = 0;
      num_checks = 0;
      seed = $urandom(94);
      repeat (10) @(negedge clk_sys_in);
      srst_in = 1'b0;
      @(negedge clk_sys_in);
      chk_val(lvl_out, '0, "reset level");
      chk_val(pin_oe_n, 1'b1, "pin released");
      chk_val(osc_ext, 1'b0, "internal source");
      chk_val(dev_en, 1'b0, "disabled after reset");
      repeat (3) @(negedge clk_sys_in);
      chk_val(dev_en, 1'b1, "enabled");
      $display("test reset done");
      for (i = 0; i < NCH; i++) begin
         w1 = mk(1'b0, i[3:0], 10'($urandom));
         frame(w1, 16, i[0], 1'b1);
      end
      settle("channels");
      for (i = 12; i < 16; i++) begin
         frame(mk(1'b1, i[3:0], 10'h3FF), 16, 0, 0);
      end
      chk_val(osc_ext, 1'b1, "external source");
      chk_val(pin_oe_n, 1'b1, "pin as input");
      for (i = 0; i < 4; i++) begin
         refresh_clock_pin_in = i[0];
         repeat (5) @(negedge clk_sys_in);
         chk_val(rclk, i[0], "external clock");
      end
      settle("bad address");
      frame(mk(1'b0, 4'h0, 10'h155), 15, 0, 0);
      chk_val(osc_ext, 1'b1, "short frame ignored");
      settle("short frame");
      w1 = mk(1'b0, 4'h5, 10'($urandom));
      w2 = mk(1'b0, 4'h9, 10'($urandom));
      frame({w1, w2}, 32, 0, 1);
      chk_val(host.seen_r[16:1], w1, "chain output");
      chk_val(pin_oe_n, 1'b0, "pin driven");
      settle("chain");
      edge_wait(cnt);
      edge_wait(cnt);
      chk_val(cnt, rdsp_pkg::OSC_HALF_CYCLES, "half period");
      $display("test oscillator done");
      shutdown_in = 1'b1;
      frame(mk(1'b0, 4'hB, 10'($urandom)), 16, 0, 1);
      chk_val(dev_en, 1'b0, "shutdown");
      shutdown_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk_val(dev_en, 1'b1, "wake");
      settle("shutdown");
      results();
   end

   // Whole run is some 50 us; cut a hang well after that
   initial begin
      #1_000_000;
      chk_val(1'b1, 1'b0, "timeout");
      results();
   end
endmodule : rdsp_tb_top
